// *** bench/madc_host_model.sv ***
// behavioural host driving the 3-wire serial control port
`timescale 1ns/1ps
module madc_host_model (
    input wire logic clk_sys,
    output logic control_select_n,
    output logic control_serial_clock,
    output logic control_serial_data_in
);
    // idle: deselected, serial clock parked high and still
    initial begin
        control_select_n = 1'b1;
        control_serial_clock = 1'b1;
        control_serial_data_in = 1'b0;
    end
    // top nBits of the frame, msb first, each held around its clock rise
    task automatic send_frame(input logic [15:0] frame, input int nBits);
        control_select_n <= 1'b0;
        for (int i = 15; i > 15 - nBits; i--) begin
            @(posedge clk_sys);
            control_serial_data_in <= frame[i];
            control_serial_clock <= 1'b0;
            repeat (4) @(posedge clk_sys);
            control_serial_clock <= 1'b1;
            repeat (3) @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
        control_select_n <= 1'b1;
        // released line shows the inverse so a stale bit cannot pass
        control_serial_data_in <= ~control_serial_data_in;
        repeat (8) @(posedge clk_sys);
    endtask : send_frame
endmodule : madc_host_model

// *** bench/test_mono_adc_control_registers.sv ***
// self-checking bench for the control register bank and its serial port
`timescale 1ns/1ps
module test_mono_adc_control_registers;
    logic clk_sys, reset_n, sampleTick, serSelectN, serClock, serData;
    logic adcPathPower, commonRefPower, pllPower, masterSelect, inputSourceSelect;
    logic inputTypeSelect, micBiasPower, bitClockPolarity, frameSyncPhase, clkOutEnable;
    logic bypassSelect, autoLevelEnable, limiterZeroCrossDisable, extMasterSelect;
    logic allPowerDown, adcDataValid, initBusy;
    logic [3:0] pllRefSelect, sampleRateSelect, extMasterUnlockKey;
    logic [1:0] micAmpGain, audioFormatSelect, bitClockOutRate, highpassCutoffSelect;
    logic [1:0] clkOutDivider, recoveryWaitSelect, zeroCrossTimeoutSelect;
    logic [7:0] inputVolumeLevel, recoveryReferenceLevel, levelModeBits;
    logic [7:0] snap [13];
    int nErrors = 0;
    int cmpCount = 0;
    // register table: address, reset value, writable bits
    localparam logic [4:0] REG_ADDR [13] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15,
        5'h16, 5'h18, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
    localparam logic [7:0] REG_RST [13] = '{8'h00, 8'h24, 8'h00, 8'h01, 8'h23, 8'h1f,
        8'h00, 8'h91, 8'h00, 8'he1, 8'h00, 8'ha0, 8'h00};
    localparam logic [7:0] REG_MASK [13] = '{8'h05, 8'h3f, 8'h15, 8'h03, 8'h0f, 8'hff,
        8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hf0, 8'h02};

    madc_host_model madc_host_model_i (.clk_sys(clk_sys), .control_select_n(serSelectN),
        .control_serial_clock(serClock), .control_serial_data_in(serData));
    madc_ctrl_regs madc_ctrl_regs_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .control_select_n(serSelectN), .control_serial_clock(serClock),
        .control_serial_data_in(serData), .sampleTick(sampleTick),
        .adcPathPower(adcPathPower), .commonRefPower(commonRefPower), .pllPower(pllPower),
        .masterSelect(masterSelect), .pllRefSelect(pllRefSelect),
        .inputSourceSelect(inputSourceSelect), .inputTypeSelect(inputTypeSelect),
        .micBiasPower(micBiasPower), .micAmpGain(micAmpGain),
        .audioFormatSelect(audioFormatSelect), .bitClockPolarity(bitClockPolarity),
        .frameSyncPhase(frameSyncPhase), .sampleRateSelect(sampleRateSelect),
        .bitClockOutRate(bitClockOutRate), .highpassCutoffSelect(highpassCutoffSelect),
        .clkOutEnable(clkOutEnable), .clkOutDivider(clkOutDivider),
        .bypassSelect(bypassSelect), .inputVolumeLevel(inputVolumeLevel),
        .recoveryWaitSelect(recoveryWaitSelect),
        .zeroCrossTimeoutSelect(zeroCrossTimeoutSelect),
        .recoveryReferenceLevel(recoveryReferenceLevel), .levelModeBits(levelModeBits),
        .autoLevelEnable(autoLevelEnable), .limiterZeroCrossDisable(limiterZeroCrossDisable),
        .extMasterUnlockKey(extMasterUnlockKey), .extMasterSelect(extMasterSelect),
        .allPowerDown(allPowerDown), .adcDataValid(adcDataValid), .initBusy(initBusy));

    // rebuild a register byte from the field outputs
    function automatic logic [7:0] image(input int k);
        case (k)
            0: image = {5'h0, commonRefPower, 1'b0, adcPathPower};
            1: image = {2'h0, pllRefSelect, masterSelect, pllPower};
            2: image = {3'h0, micBiasPower, 1'b0, inputTypeSelect, 1'b0, inputSourceSelect};
            3: image = {6'h0, micAmpGain};
            4: image = {4'h2, frameSyncPhase, bitClockPolarity, audioFormatSelect};
            5: image = {highpassCutoffSelect, bitClockOutRate, sampleRateSelect};
            6: image = {4'h0, bypassSelect, clkOutEnable, clkOutDivider};
            7: image = inputVolumeLevel;
            8: image = {4'h0, zeroCrossTimeoutSelect, recoveryWaitSelect};
            9: image = recoveryReferenceLevel;
            10: image = levelModeBits;
            11: image = {extMasterUnlockKey, 4'h0};
            default: image = {6'h0, extMasterSelect, 1'b0};
        endcase
    endfunction : image

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp);
        check8({7'h0, got}, {7'h0, exp});
    endtask : check1

    task automatic reportAndStop();
        $display("comparisons=%0d mismatches=%0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : reportAndStop

    // one well-formed write frame: chip 10, write 1
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        madc_host_model_i.send_frame({2'h2, 1'b1, a, d}, 16);
    endtask : wr

    task automatic t_reset_values();
        for (int k = 0; k < 13; k++) begin
            check8(image(k), REG_RST[k]);
        end
        check1(allPowerDown, 1'b1);
        check1(adcDataValid, 1'b0);
    endtask : t_reset_values

    // registers 11h to 1ch, only writable bits land, format bit 5 stays 1
    task automatic t_write_all(input logic [7:0] d);
        for (int k = 1; k < 11; k++) begin
            wr(REG_ADDR[k], d);
            check8(image(k), (d & REG_MASK[k]) | ((k == 4) ? 8'h20 : 8'h00));
        end
        check1(autoLevelEnable, d[7]);
        check1(limiterZeroCrossDisable, d[6]);
    endtask : t_write_all

    // malformed frames must leave every register untouched
    task automatic t_refuse();
        for (int k = 0; k < 13; k++) snap[k] = image(k);
        madc_host_model_i.send_frame({2'h1, 1'b1, 5'h18, 8'h00}, 16);
        madc_host_model_i.send_frame({2'h2, 1'b0, 5'h18, 8'h00}, 16);
        madc_host_model_i.send_frame({2'h2, 1'b1, 5'h17, 8'h00}, 16);
        madc_host_model_i.send_frame({2'h2, 1'b1, 5'h18, 8'h00}, 15);
        for (int k = 0; k < 13; k++) check8(image(k), snap[k]);
    endtask : t_refuse

    task automatic t_unlock();
        wr(5'h1e, 8'h02);
        check1(extMasterSelect, 1'b0);
        wr(5'h1d, 8'h50);
        wr(5'h1e, 8'h02);
        check1(extMasterSelect, 1'b1);
        wr(5'h1d, 8'ha0);
        wr(5'h1e, 8'h00);
        check1(extMasterSelect, 1'b1);
    endtask : t_unlock

    // init length follows the highpass field; count ticks to the boundary
    task automatic t_init(input logic [1:0] hpf, input int n);
        wr(5'h15, {hpf, 6'h1f});
        wr(5'h10, 8'h05);
        check1(initBusy, 1'b1);
        repeat (n - 1) begin
            @(posedge clk_sys) sampleTick <= 1'b1;
            @(posedge clk_sys) sampleTick <= 1'b0;
        end
        @(posedge clk_sys);
        check1(adcDataValid, 1'b0);
        @(posedge clk_sys) sampleTick <= 1'b1;
        @(posedge clk_sys) sampleTick <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (adcDataValid !== 1'b1) @(posedge clk_sys);
        end
        check1(adcDataValid, 1'b1);
        if (adcDataValid !== 1'b1) reportAndStop();
        check1(initBusy, 1'b0);
        wr(5'h10, 8'h04);
        check1(adcDataValid, 1'b0);
        check1(commonRefPower, 1'b1);
    endtask : t_init

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial begin
        reset_n <= 1'b0; // nba: the reset edge is not lost at time zero
        sampleTick = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset_values();
        wr(5'h10, 8'h04);
        t_write_all(8'hb5);
        t_write_all(8'h4a);
        t_refuse();
        t_unlock();
        t_init(2'h0, 3088);
        t_init(2'h1, 1552);
        t_init(2'h2, 784);
        check1(allPowerDown, 1'b0);
        wr(5'h10, 8'h00);
        check1(allPowerDown, 1'b1);
        check8(inputVolumeLevel, 8'h4a);
        // power-down pin in mid-init wipes everything at once
        wr(5'h10, 8'h05);
        reset_n <= 1'b0;
        @(posedge clk_sys);
        t_reset_values();
        check1(initBusy, 1'b0);
        // second release: defaults stay and the port takes frames again
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset_values();
        wr(5'h18, 8'h33);
        check8(inputVolumeLevel, 8'h33);
        reportAndStop();
    end
endmodule : test_mono_adc_control_registers

// *** verilog/madc_ctrl_pkg.sv ***
// constants for the mono adc control register bank
package madc_ctrl_pkg;
    // register addresses (5-bit)
    localparam logic [4:0] ADDR_POWER = 5'h10;
    localparam logic [4:0] ADDR_PLL = 5'h11;
    localparam logic [4:0] ADDR_SIGNAL = 5'h12;
    localparam logic [4:0] ADDR_MICGAIN = 5'h13;
    localparam logic [4:0] ADDR_FORMAT = 5'h14;
    localparam logic [4:0] ADDR_RATE = 5'h15;
    localparam logic [4:0] ADDR_CLKOUT = 5'h16;
    localparam logic [4:0] ADDR_VOLUME = 5'h18;
    localparam logic [4:0] ADDR_TIMER = 5'h1a;
    localparam logic [4:0] ADDR_LVLREF = 5'h1b;
    localparam logic [4:0] ADDR_LVLMODE = 5'h1c;
    localparam logic [4:0] ADDR_UNLOCK = 5'h1d;
    localparam logic [4:0] ADDR_EXTMODE = 5'h1e;
    // writable bit masks; fixed bits read as their documented constants
    localparam logic [7:0] MASK_POWER = 8'h05;
    localparam logic [7:0] MASK_PLL = 8'h3f;
    localparam logic [7:0] MASK_SIGNAL = 8'h15;
    localparam logic [7:0] MASK_MICGAIN = 8'h03;
    localparam logic [7:0] MASK_FORMAT = 8'h0f;
    localparam logic [7:0] FIXED_FORMAT = 8'h20;
    localparam logic [7:0] MASK_CLKOUT = 8'h0f;
    localparam logic [7:0] MASK_TIMER = 8'h0f;
    localparam logic [7:0] MASK_UNLOCK = 8'hf0;
    localparam logic [7:0] MASK_EXTMODE = 8'h02;
    // reset values
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_PLL = 8'h24;
    localparam logic [7:0] RST_SIGNAL = 8'h00;
    localparam logic [7:0] RST_MICGAIN = 8'h01;
    localparam logic [7:0] RST_FORMAT = 8'h23;
    localparam logic [7:0] RST_RATE = 8'h1f;
    localparam logic [7:0] RST_CLKOUT = 8'h00;
    localparam logic [7:0] RST_VOLUME = 8'h91;
    localparam logic [7:0] RST_TIMER = 8'h00;
    localparam logic [7:0] RST_LVLREF = 8'he1;
    localparam logic [7:0] RST_LVLMODE = 8'h00;
    localparam logic [7:0] RST_UNLOCK = 8'ha0;
    localparam logic [7:0] RST_EXTMODE = 8'h00;
    // field positions
    localparam int BIT_ADC_PWR = 0;
    localparam int BIT_REF_PWR = 2;
    localparam int BIT_PLL_PWR = 0;
    localparam int BIT_MASTER = 1;
    localparam int POS_PLL_REF = 2;
    localparam int BIT_SRC = 0;
    localparam int BIT_DIFF = 2;
    localparam int BIT_MICB = 4;
    localparam int BIT_BCKPOL = 2;
    localparam int BIT_FSPHASE = 3;
    localparam int POS_HPF = 6;
    localparam int POS_BCKRATE = 4;
    localparam int BIT_CLKOE = 2;
    localparam int BIT_BYPASS = 3;
    localparam int BIT_EXTM = 1;
    localparam int BIT_ALC = 7;
    localparam int BIT_ZCDIS = 6;
    localparam int POS_KEY = 4;
    localparam logic [3:0] KEY_OPEN = 4'h5;
    // serial frame: 2 chip address, 1 write, 5 address, 8 data
    localparam int FRAME_BITS = 16;
    localparam logic [1:0] CHIP_ADDR = 2'h2;
    // initialization cycle lengths in sample periods, per highpass setting
    localparam int INIT_FS_00 = 3088;
    localparam int INIT_FS_01 = 1552;
    localparam int INIT_FS_10 = 784;
endpackage : madc_ctrl_pkg

// *** verilog/madc_ctrl_regs.sv ***
// control register bank of the mono adc with its 3-wire serial write port
//
// What this block does
// - adc power rising starts init cycle
// - power-down pin resets and powers off
// - each power bit gates its block
// - pll power bit selects pll mode
// - master select bit, default slave
// - pll reference field resets to 1001
// - input source and type select bits
// - mic bias pin high-z unless enabled
// - mic gain resets to 01
// - audio format resets to 11
// - bit clock polarity in dsp mode
// - frame sync phase in dsp mode
// - rate field resets to 1111
// - bit clock out rate resets 01
// - highpass field sets init length
// - clock output low unless enabled
// - input volume resets to 91h
// - level timers reset to 00
// - zero-cross disable and level enable
// - mode register writable only under key
// - sixteen-bit msb-first frame latched on 16th
`timescale 1ns/1ps
module madc_ctrl_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic control_select_n,
    input wire logic control_serial_clock,
    input wire logic control_serial_data_in,
    input wire logic sampleTick,
    output logic adcPathPower,
    output logic commonRefPower,
    output logic pllPower,
    output logic masterSelect,
    output logic [3:0] pllRefSelect,
    output logic inputSourceSelect,
    output logic inputTypeSelect,
    output logic micBiasPower,
    output logic [1:0] micAmpGain,
    output logic [1:0] audioFormatSelect,
    output logic bitClockPolarity,
    output logic frameSyncPhase,
    output logic [3:0] sampleRateSelect,
    output logic [1:0] bitClockOutRate,
    output logic [1:0] highpassCutoffSelect,
    output logic clkOutEnable,
    output logic [1:0] clkOutDivider,
    output logic bypassSelect,
    output logic [7:0] inputVolumeLevel,
    output logic [1:0] recoveryWaitSelect,
    output logic [1:0] zeroCrossTimeoutSelect,
    output logic [7:0] recoveryReferenceLevel,
    output logic [7:0] levelModeBits,
    output logic autoLevelEnable,
    output logic limiterZeroCrossDisable,
    output logic [3:0] extMasterUnlockKey,
    output logic extMasterSelect,
    output logic allPowerDown,
    output logic adcDataValid,
    output logic initBusy
);
    typedef struct packed {
        // pin synchronisers and the frame shifter
        logic [2:0] csSync;
        logic [2:0] sclkSync;
        logic [1:0] sdiSync;
        logic [4:0] bitCount;
        logic [15:0] shiftReg;
        // register images, one byte per address
        logic [7:0] power;
        logic [7:0] pll;
        logic [7:0] signal;
        logic [7:0] micGain;
        logic [7:0] format;
        logic [7:0] rate;
        logic [7:0] clkOut;
        logic [7:0] volume;
        logic [7:0] timer;
        logic [7:0] lvlRef;
        logic [7:0] lvlMode;
        logic [7:0] unlock;
        logic [7:0] extMode;
        // init cycle tracking
        logic adcPwrLast;
        logic [11:0] initCount;
        logic initRun;
        logic dataValid;
    } madc_state_t;

    madc_state_t st;
    madc_state_t next_st;
    logic [1:0] rstSync;
    logic rstN;
    logic sclkRise;
    logic csLow;
    logic [15:0] frameWord;
    logic frameDone;
    logic [4:0] wrAddr;
    logic [7:0] wrData;

    // every check below samples on the system clock, off while in reset
    default clocking chkClk @(posedge clk_sys);
    endclocking
    default disable iff (!rstN);

    // init cycle length in sample periods for a highpass setting
    function automatic logic [11:0] madc_init_len(input logic [1:0] hpf);
        logic [11:0] len;
        len = 12'(madc_ctrl_pkg::INIT_FS_00);
        unique case (hpf)
            2'h0: len = 12'(madc_ctrl_pkg::INIT_FS_00);
            2'h1: len = 12'(madc_ctrl_pkg::INIT_FS_01);
            2'h2: len = 12'(madc_ctrl_pkg::INIT_FS_10);
            2'h3: len = 12'(madc_ctrl_pkg::INIT_FS_00); // setting not allowed; longest is safe
        endcase
        return len;
    endfunction : madc_init_len

    // masked write keeping fixed bits at their constant values
    function automatic logic [7:0] madc_merge(input logic [7:0] d, input logic [7:0] m,
                                              input logic [7:0] fixed);
        return (d & m) | (fixed & ~m);
    endfunction : madc_merge

    // power-down pin release through two flops; asserts at once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // serial pins only looked at after the second sync stage
    assign sclkRise = st.sclkSync[1] & ~st.sclkSync[2];
    assign csLow = ~st.csSync[1];
    assign frameWord = {st.shiftReg[14:0], st.sdiSync[1]};
    assign frameDone = sclkRise && csLow && (st.bitCount == 5'(madc_ctrl_pkg::FRAME_BITS - 1));
    assign wrAddr = frameWord[12:8];
    assign wrData = frameWord[7:0];

    always_comb begin
        next_st = st;
        next_st.csSync = {st.csSync[1:0], control_select_n};
        next_st.sclkSync = {st.sclkSync[1:0], control_serial_clock};
        next_st.sdiSync = {st.sdiSync[0], control_serial_data_in};
        // frame shifter: bits in msb first, restart whenever select is high
        if (!csLow) begin
            next_st.bitCount = 5'h0;
        end else if (sclkRise && st.bitCount < 5'(madc_ctrl_pkg::FRAME_BITS)) begin
            // count stops at a full frame so trailing clocks cannot wrap it
            next_st.shiftReg = frameWord;
            next_st.bitCount = st.bitCount + 5'h1;
        end

        // latch on the 16th rising edge if chip address and write bit match
        if (frameDone && frameWord[15:14] == madc_ctrl_pkg::CHIP_ADDR && frameWord[13]) begin
            unique case (wrAddr)
                madc_ctrl_pkg::ADDR_POWER:
                    next_st.power = madc_merge(wrData, madc_ctrl_pkg::MASK_POWER, 8'h00);
                madc_ctrl_pkg::ADDR_PLL:
                    next_st.pll = madc_merge(wrData, madc_ctrl_pkg::MASK_PLL, 8'h00);
                madc_ctrl_pkg::ADDR_SIGNAL:
                    next_st.signal = madc_merge(wrData, madc_ctrl_pkg::MASK_SIGNAL, 8'h00);
                madc_ctrl_pkg::ADDR_MICGAIN:
                    next_st.micGain = madc_merge(wrData, madc_ctrl_pkg::MASK_MICGAIN, 8'h00);
                madc_ctrl_pkg::ADDR_FORMAT:
                    next_st.format = madc_merge(wrData, madc_ctrl_pkg::MASK_FORMAT,
                                                madc_ctrl_pkg::FIXED_FORMAT);
                madc_ctrl_pkg::ADDR_RATE:
                    next_st.rate = wrData;
                madc_ctrl_pkg::ADDR_CLKOUT:
                    next_st.clkOut = madc_merge(wrData, madc_ctrl_pkg::MASK_CLKOUT, 8'h00);
                madc_ctrl_pkg::ADDR_VOLUME:
                    next_st.volume = wrData;
                madc_ctrl_pkg::ADDR_TIMER:
                    next_st.timer = madc_merge(wrData, madc_ctrl_pkg::MASK_TIMER, 8'h00);
                madc_ctrl_pkg::ADDR_LVLREF:
                    next_st.lvlRef = wrData;
                madc_ctrl_pkg::ADDR_LVLMODE:
                    next_st.lvlMode = wrData;
                madc_ctrl_pkg::ADDR_UNLOCK:
                    next_st.unlock = madc_merge(wrData, madc_ctrl_pkg::MASK_UNLOCK, 8'h00);
                madc_ctrl_pkg::ADDR_EXTMODE: begin
                    // locked writes vanish, stored value stays
                    if (st.unlock[7:4] == madc_ctrl_pkg::KEY_OPEN) begin
                        next_st.extMode = madc_merge(wrData, madc_ctrl_pkg::MASK_EXTMODE, 8'h00);
                    end
                end
                default: ; // unmapped addresses must not be written; ignored
            endcase
        end

        // init cycle counts sample ticks after adc power rises
        next_st.adcPwrLast = st.power[madc_ctrl_pkg::BIT_ADC_PWR];
        if (!st.power[madc_ctrl_pkg::BIT_ADC_PWR]) begin
            next_st.initRun = 1'b0;
            next_st.dataValid = 1'b0;
            next_st.initCount = 12'h0;
        end else if (!st.adcPwrLast) begin
            next_st.initRun = 1'b1;
            next_st.initCount = madc_init_len(st.rate[7:6]);
        end else if (st.initRun && sampleTick) begin
            next_st.initCount = st.initCount - 12'h1;
            if (st.initCount == 12'h1) begin
                next_st.initRun = 1'b0;
                next_st.dataValid = 1'b1;
            end
        end
    end

    // whole state; reset returns every register to default
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            st <= '0;
            st.csSync <= 3'h7;
            st.sclkSync <= 3'h7; // idle clock is high: no false edge after reset
            st.power <= madc_ctrl_pkg::RST_POWER;
            st.pll <= madc_ctrl_pkg::RST_PLL;
            st.signal <= madc_ctrl_pkg::RST_SIGNAL;
            st.micGain <= madc_ctrl_pkg::RST_MICGAIN;
            st.format <= madc_ctrl_pkg::RST_FORMAT;
            st.rate <= madc_ctrl_pkg::RST_RATE;
            st.clkOut <= madc_ctrl_pkg::RST_CLKOUT;
            st.volume <= madc_ctrl_pkg::RST_VOLUME;
            st.timer <= madc_ctrl_pkg::RST_TIMER;
            st.lvlRef <= madc_ctrl_pkg::RST_LVLREF;
            st.lvlMode <= madc_ctrl_pkg::RST_LVLMODE;
            st.unlock <= madc_ctrl_pkg::RST_UNLOCK;
            st.extMode <= madc_ctrl_pkg::RST_EXTMODE;
        end else begin
            st <= next_st;
        end
    end

    // decoded outputs registered once more so every port leaves a flop;
    // block enables drop to zero with the pin as well
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            adcPathPower <= 1'b0;
            commonRefPower <= 1'b0;
            pllPower <= 1'b0;
            masterSelect <= 1'b0;
            pllRefSelect <= 4'h9;
            inputSourceSelect <= 1'b0;
            inputTypeSelect <= 1'b0;
            micBiasPower <= 1'b0;
            micAmpGain <= 2'h1;
            audioFormatSelect <= 2'h3;
            bitClockPolarity <= 1'b0;
            frameSyncPhase <= 1'b0;
            sampleRateSelect <= 4'hf;
            bitClockOutRate <= 2'h1;
            highpassCutoffSelect <= 2'h0;
            clkOutEnable <= 1'b0;
            clkOutDivider <= 2'h0;
            bypassSelect <= 1'b0;
            inputVolumeLevel <= 8'h91;
            recoveryWaitSelect <= 2'h0;
            zeroCrossTimeoutSelect <= 2'h0;
            recoveryReferenceLevel <= 8'he1;
            levelModeBits <= 8'h00;
            autoLevelEnable <= 1'b0;
            limiterZeroCrossDisable <= 1'b0;
            extMasterUnlockKey <= 4'ha;
            extMasterSelect <= 1'b0;
            allPowerDown <= 1'b1;
            adcDataValid <= 1'b0;
            initBusy <= 1'b0;
        end else begin
            // power, clock mode and input path fields
            adcPathPower <= st.power[madc_ctrl_pkg::BIT_ADC_PWR];
            commonRefPower <= st.power[madc_ctrl_pkg::BIT_REF_PWR];
            pllPower <= st.pll[madc_ctrl_pkg::BIT_PLL_PWR];
            masterSelect <= st.pll[madc_ctrl_pkg::BIT_MASTER];
            pllRefSelect <= st.pll[madc_ctrl_pkg::POS_PLL_REF +: 4];
            inputSourceSelect <= st.signal[madc_ctrl_pkg::BIT_SRC];
            inputTypeSelect <= st.signal[madc_ctrl_pkg::BIT_DIFF];
            micBiasPower <= st.signal[madc_ctrl_pkg::BIT_MICB];
            micAmpGain <= st.micGain[1:0];
            audioFormatSelect <= st.format[1:0];
            bitClockPolarity <= st.format[madc_ctrl_pkg::BIT_BCKPOL];
            frameSyncPhase <= st.format[madc_ctrl_pkg::BIT_FSPHASE];
            sampleRateSelect <= st.rate[3:0];
            bitClockOutRate <= st.rate[madc_ctrl_pkg::POS_BCKRATE +: 2];
            highpassCutoffSelect <= st.rate[madc_ctrl_pkg::POS_HPF +: 2];
            clkOutEnable <= st.clkOut[madc_ctrl_pkg::BIT_CLKOE];
            clkOutDivider <= st.clkOut[1:0];
            bypassSelect <= st.clkOut[madc_ctrl_pkg::BIT_BYPASS];
            // volume, level control and mode key, as stored
            inputVolumeLevel <= st.volume;
            recoveryWaitSelect <= st.timer[1:0];
            zeroCrossTimeoutSelect <= st.timer[3:2];
            recoveryReferenceLevel <= st.lvlRef;
            levelModeBits <= st.lvlMode;
            autoLevelEnable <= st.lvlMode[madc_ctrl_pkg::BIT_ALC];
            limiterZeroCrossDisable <= st.lvlMode[madc_ctrl_pkg::BIT_ZCDIS];
            extMasterUnlockKey <= st.unlock[madc_ctrl_pkg::POS_KEY +: 4];
            extMasterSelect <= st.extMode[madc_ctrl_pkg::BIT_EXTM];
            // registers keep their contents in this state
            allPowerDown <= ~(st.power[madc_ctrl_pkg::BIT_REF_PWR]
                | st.power[madc_ctrl_pkg::BIT_ADC_PWR]
                | st.pll[madc_ctrl_pkg::BIT_PLL_PWR]
                | st.clkOut[madc_ctrl_pkg::BIT_CLKOE]);
            adcDataValid <= st.dataValid;
            initBusy <= st.initRun;
        end
    end

    // mode register only moves under the key
    chk_locked_write_kept: assert property (
        st.unlock[7:4] != madc_ctrl_pkg::KEY_OPEN |=> $stable(st.extMode))
        else $error("mode register changed while locked");

    chk_ext_needs_key: assert property (
        $changed(st.extMode) |-> $past(st.unlock[7:4]) == madc_ctrl_pkg::KEY_OPEN)
        else $error("mode register written without key");

    // init cycle starts on the power edge; no data before its end
    chk_init_starts: assert property (
        $rose(st.power[0]) |=> st.initRun && !st.dataValid)
        else $error("init cycle did not start");

    chk_no_data_early: assert property (
        st.initRun |-> !st.dataValid)
        else $error("data valid during init");

    // each power bit reaches its own enable one flop later
    chk_power_gate: assert property (
        !st.power[0] |=> !adcPathPower ##1 !adcDataValid)
        else $error("adc not powered down");

    chk_ref_follow: assert property (
        !st.power[madc_ctrl_pkg::BIT_REF_PWR] |=> !commonRefPower)
        else $error("reference not powered down");

    chk_pll_follow: assert property (
        st.pll[madc_ctrl_pkg::BIT_PLL_PWR] |=> pllPower)
        else $error("pll mode not selected");

    chk_all_down: assert property (
        allPowerDown |-> !adcPathPower && !commonRefPower && !pllPower && !clkOutEnable)
        else $error("block enabled while all powered down");

    chk_clkout_follow: assert property (
        !st.clkOut[2] |=> !clkOutEnable)
        else $error("clock output enabled while off");

    // an accepted volume frame lands its data byte; extra clocks do nothing
    chk_frame_latch: assert property (
        frameDone && frameWord[15:13] == {madc_ctrl_pkg::CHIP_ADDR, 1'b1}
        && wrAddr == madc_ctrl_pkg::ADDR_VOLUME |=> st.volume == $past(wrData))
        else $error("frame not latched into volume");

    chk_count_saturates: assert property (
        csLow && st.bitCount == 5'(madc_ctrl_pkg::FRAME_BITS)
        |=> st.bitCount == 5'(madc_ctrl_pkg::FRAME_BITS))
        else $error("frame counter moved past a full frame");

    // fixed bit pattern of the format register never moves
    chk_format_fixed: assert property (
        st.format[7:4] == 4'h2)
        else $error("fixed format bits corrupted");

    // scenarios the bench is meant to reach
    cov_frame: cover property (frameDone);
    cov_init_done: cover property ($rose(st.dataValid));
    cov_ext_set: cover property ($rose(st.extMode[1]));
    cov_locked: cover property (
        frameDone && wrAddr == madc_ctrl_pkg::ADDR_EXTMODE && st.unlock[7:4] != 4'h5);
endmodule : madc_ctrl_regs
